// ==== core/lbsd_pkg.sv ====
// Purpose: shared constants and types for the lin break/sync block
// Assumes: 32-bit axi4-lite register bus, 100 MHz clock
// Notes: bit layout of the lin mode register follows the hardware map
package lbsd_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] LBSD_OFS_CTRL = 8'h00;
    localparam logic [7:0] LBSD_OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] LBSD_OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] LBSD_OFS_BAUD = 8'h0c;
    localparam logic [7:0] LBSD_CTRL_RESET = 8'h00;
    // ------------------------------------------------------------
    // lin mode control/status bit positions
    // ------------------------------------------------------------
    localparam int LBSD_BIT_SYNC_DET_IE = 0;
    localparam int LBSD_BIT_SYNC_TO_IE = 1;
    localparam int LBSD_BIT_BREAK_IE = 2;
    localparam int LBSD_BIT_MODE_EN = 3;
    localparam int LBSD_BIT_SYNC_DET = 4;
    localparam int LBSD_BIT_SYNC_TO = 5;
    localparam int LBSD_BIT_BREAK_DONE = 6;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int LBSD_CNT_W = 16;
    localparam int LBSD_BREAK_MIN_BITS = 11;
    localparam int LBSD_PRESC_W = 8;
    localparam logic [1:0] LBSD_RESP_OKAY = 2'b00;
    localparam logic [1:0] LBSD_RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        LBSD_IDLE = 5'b00001,
        LBSD_BREAK = 5'b00010,
        LBSD_DELIM = 5'b00100,
        LBSD_SYNC = 5'b01000,
        LBSD_DONE = 5'b10000
    } lbsd_state_t;

    typedef struct packed {
        logic break_done;
        logic sync_timeout;
        logic sync_detect;
    } lbsd_events_t;
endpackage

// ==== core/lbsd_sync_meas.sv ====
// Purpose: break, delimiter and sync word measurement for lin mode
// Assumes: rx already synchronised, tick_en a prescaled sample tick
// Notes: measures eight bit times across the sync word 0x55
`timescale 1ns/1ps
`default_nettype none
module lbsd_sync_meas (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic mode_en,
    input wire logic tick_en,
    input wire logic rx,
    input wire logic [lbsd_pkg::LBSD_CNT_W-1:0] bit_ticks,
    output lbsd_pkg::lbsd_events_t events,
    output logic [lbsd_pkg::LBSD_CNT_W-1:0] baud_value,
    output logic baud_load,
    output lbsd_pkg::lbsd_state_t state
);
    // ------------------------------------------------------------
    // edge detection and counters
    // ------------------------------------------------------------
    localparam int W = lbsd_pkg::LBSD_CNT_W;
    logic rx_q;
    logic [W-1:0] cnt;
    logic [2:0] falls;
    lbsd_pkg::lbsd_state_t next_state;
    wire fall = rx_q & ~rx;
    wire cnt_max = &cnt;
    wire [W+4:0] brk_min = (W+5)'(bit_ticks) *
        (W+5)'(lbsd_pkg::LBSD_BREAK_MIN_BITS);
    wire brk_ok = ({5'h00, cnt} >= brk_min);
    // the start fall resets the counters, so four more falls end the word
    wire last_fall = fall && falls == 3'h3;

    always_comb begin
        next_state = state;
        case (state)
            lbsd_pkg::LBSD_IDLE: if (fall) next_state = lbsd_pkg::LBSD_BREAK;
            lbsd_pkg::LBSD_BREAK: begin
                if (rx) next_state = brk_ok ? lbsd_pkg::LBSD_DELIM
                                            : lbsd_pkg::LBSD_IDLE;
            end
            // sync is only accepted after a valid break and delimiter
            lbsd_pkg::LBSD_DELIM: begin
                if (fall) next_state = lbsd_pkg::LBSD_SYNC;
            end
            lbsd_pkg::LBSD_SYNC: begin
                if (cnt_max) next_state = lbsd_pkg::LBSD_IDLE;
                else if (last_fall) next_state = lbsd_pkg::LBSD_DONE;
            end
            lbsd_pkg::LBSD_DONE: next_state = lbsd_pkg::LBSD_IDLE;
            default: next_state = lbsd_pkg::LBSD_IDLE;
        endcase
        if (!mode_en) next_state = lbsd_pkg::LBSD_IDLE;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= lbsd_pkg::LBSD_IDLE;
            rx_q <= 1'b1;
        end else if (ce) begin
            state <= next_state;
            rx_q <= rx;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
            falls <= 3'h0;
        end else if (ce) begin
            if (next_state != state) begin
                cnt <= '0;
                falls <= 3'h0;
            end else begin
                if (tick_en && !cnt_max) cnt <= cnt + W'(1);
                if (fall) falls <= falls + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // results
    // ------------------------------------------------------------
    wire sync_ok = (state == lbsd_pkg::LBSD_SYNC) && last_fall && !cnt_max;
    wire sync_ovf = (state == lbsd_pkg::LBSD_SYNC) && cnt_max && mode_en;
    wire brk_evt = (state == lbsd_pkg::LBSD_BREAK) && rx && brk_ok && mode_en;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            events <= '0;
            baud_value <= '0;
            baud_load <= 1'b0;
        end else if (ce) begin
            events.break_done <= brk_evt;
            events.sync_timeout <= sync_ovf;
            events.sync_detect <= sync_ok && mode_en;
            // overflow leaves the baud setting untouched
            baud_load <= sync_ok && mode_en;
            // the tick of the start edge is lost to the counter reset
            if (sync_ok) baud_value <= (cnt + W'(1)) >> 3;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sync_after_break;
        @(posedge clk) disable iff (!reset_n)
        (ce && state == lbsd_pkg::LBSD_SYNC) |->
            $past(state) inside {lbsd_pkg::LBSD_SYNC, lbsd_pkg::LBSD_DELIM};
    endproperty
    a_sync_after_break: assert property (p_sync_after_break)
        else $error("sync entered without delimiter");

    property p_timeout_no_load;
        @(posedge clk) disable iff (!reset_n)
        events.sync_timeout |-> !baud_load;
    endproperty
    a_timeout_no_load: assert property (p_timeout_no_load)
        else $error("baud loaded on sync timeout");

    property p_detect_loads;
        @(posedge clk) disable iff (!reset_n)
        events.sync_detect |-> baud_load;
    endproperty
    a_detect_loads: assert property (p_detect_loads)
        else $error("sync detect without baud load");

    c_sync_done: cover property (@(posedge clk) events.sync_detect);
    c_sync_to: cover property (@(posedge clk) events.sync_timeout);
endmodule
`default_nettype wire

// ==== core/lbsd_top.sv ====
// Purpose: lin break/sync detection, autobaud and interrupt control
// Assumes: axi4-lite master, rx pin asynchronous to clk
// Notes: one write and one read outstanding at most
`timescale 1ns/1ps
`default_nettype none
module lbsd_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic rx_pin,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] baud_reload,
    output logic baud_reload_load,
    output logic irq
);
    // ------------------------------------------------------------
    // pin synchroniser and prescaler
    // ------------------------------------------------------------
    logic rx_meta;
    logic rx_sync;
    logic [7:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] presc;
    logic [7:0] presc_cnt;
    logic [15:0] bit_ticks;
    lbsd_pkg::lbsd_events_t ev;
    lbsd_pkg::lbsd_state_t meas_state;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else if (ce) begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    wire tick = (presc_cnt == presc);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) presc_cnt <= 8'h00;
        else if (ce) presc_cnt <= tick ? 8'h00 : presc_cnt + 8'h01;
    end

    wire mode_en = ctrl[lbsd_pkg::LBSD_BIT_MODE_EN];

    lbsd_sync_meas u_meas (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .mode_en(mode_en),
        .tick_en(tick),
        .rx(rx_sync),
        .bit_ticks(bit_ticks),
        .events(ev),
        .baud_value(baud_reload),
        .baud_load(baud_reload_load),
        .state(meas_state)
    );

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // no ready while frozen, or a handshake would be lost
    assign s_axi_awready = ce && !aw_held && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_held && !s_axi_bvalid;
    wire wr_go = aw_held && w_held;
    wire wr_ctrl = wr_go && aw_addr == lbsd_pkg::LBSD_OFS_CTRL && w_strb[0];
    wire wr_stat = wr_go && aw_addr == lbsd_pkg::LBSD_OFS_IRQ_STATUS
        && w_strb[0];
    wire wr_mask = wr_go && aw_addr == lbsd_pkg::LBSD_OFS_IRQ_MASK
        && w_strb[0];
    wire wr_baud = wr_go && aw_addr == lbsd_pkg::LBSD_OFS_BAUD;
    wire wr_hit = (aw_addr == lbsd_pkg::LBSD_OFS_CTRL) ||
        (aw_addr == lbsd_pkg::LBSD_OFS_IRQ_STATUS) ||
        (aw_addr == lbsd_pkg::LBSD_OFS_IRQ_MASK) ||
        (aw_addr == lbsd_pkg::LBSD_OFS_BAUD);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lbsd_pkg::LBSD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? lbsd_pkg::LBSD_RESP_OKAY
                                      : lbsd_pkg::LBSD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    wire [2:0] ev_vec = {ev.break_done, ev.sync_timeout, ev.sync_detect};
    wire [2:0] clr_vec = wr_stat ? w_data[2:0] : 3'h0;
    wire [2:0] ctrl_clr = wr_ctrl ? ~w_data[6:4] : 3'h0;

    // enables reset to zero, software read-write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= lbsd_pkg::LBSD_CTRL_RESET;
        end else if (ce && wr_ctrl) begin
            ctrl <= {4'h0, w_data[3:0]};
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= 3'h0;
        end else if (ce) begin
            status <= (status & ~clr_vec & ~ctrl_clr)
                | ev_vec;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask <= 3'h7;
            bit_ticks <= 16'h0010;
            presc <= 8'h00;
        end else if (ce) begin
            if (wr_mask) mask <= w_data[2:0];
            if (wr_baud) begin
                bit_ticks <= w_data[15:0];
                presc <= w_data[23:16];
            end
        end
    end

    wire [2:0] en_vec = ctrl[2:0];
    wire [2:0] pend = status & en_vec & mask;
    assign irq = |pend;

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    wire [7:0] ar_addr = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] ctrl_rd = {25'h0, status, ctrl[3:0]};
    wire rd_ctrl = ar_addr == lbsd_pkg::LBSD_OFS_CTRL;
    wire rd_stat = ar_addr == lbsd_pkg::LBSD_OFS_IRQ_STATUS;
    wire rd_mask = ar_addr == lbsd_pkg::LBSD_OFS_IRQ_MASK;
    wire rd_baud = ar_addr == lbsd_pkg::LBSD_OFS_BAUD;
    wire [31:0] rd_val = rd_ctrl ? ctrl_rd :
        rd_stat ? {29'h0, status} :
        rd_mask ? {29'h0, mask} :
        rd_baud ? {3'h0, meas_state, presc, bit_ticks} : 32'h0000_0000;
    wire rd_hit = rd_ctrl || rd_stat || rd_mask || rd_baud;
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lbsd_pkg::LBSD_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? lbsd_pkg::LBSD_RESP_OKAY
                                      : lbsd_pkg::LBSD_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_brk_gate;
        @(posedge clk) disable iff (!reset_n)
        (status[2] && !ctrl[2] && !(status[1] && ctrl[1] && mask[1])
            && !(status[0] && ctrl[0] && mask[0])) |-> !irq;
    endproperty
    a_brk_gate: assert property (p_brk_gate)
        else $error("break flag reached irq while disabled");

    property p_to_irq;
        @(posedge clk) disable iff (!reset_n)
        (status[1] && ctrl[1] && mask[1]) |-> irq;
    endproperty
    a_to_irq: assert property (p_to_irq)
        else $error("enabled timeout flag gave no irq");

    property p_det_irq;
        @(posedge clk) disable iff (!reset_n)
        (status[0] && ctrl[0] && mask[0]) |-> irq;
    endproperty
    a_det_irq: assert property (p_det_irq)
        else $error("enabled detect flag gave no irq");

    property p_to_set;
        @(posedge clk) disable iff (!reset_n)
        (ce && ev.sync_timeout) |=> status[1];
    endproperty
    a_to_set: assert property (p_to_set)
        else $error("timeout event lost");

    property p_det_sticky;
        @(posedge clk) disable iff (!reset_n)
        (status[0] && !(wr_stat && w_data[0]) && !(wr_ctrl && !w_data[4]))
            |=> status[0];
    endproperty
    a_det_sticky: assert property (p_det_sticky)
        else $error("detect flag dropped without clear");

    property p_irq_or;
        @(posedge clk) disable iff (!reset_n)
        irq == |(status & ctrl[2:0] & mask);
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("irq not the or of gated flags");

    property p_wr_resp;
        @(posedge clk) disable iff (!reset_n)
        (ce && wr_go) |=> s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write without response");

    property p_en_reset;
        @(posedge clk) $rose(reset_n) |-> ctrl[2:0] == 3'h0;
    endproperty
    a_en_reset: assert property (p_en_reset)
        else $error("enables not zero after reset");

    c_irq: cover property (@(posedge clk) $rose(irq));
    c_wr: cover property (@(posedge clk) wr_go);
    c_rd: cover property (@(posedge clk) s_axi_rvalid);
endmodule
`default_nettype wire

// ==== testbench/lbsd_lin_node.sv ====
// Purpose: lin bus node sending break, delimiter and byte frames
// Assumes: bit time is given in clk cycles
// Notes: the line idles recessive high, as with the bus pull-up
`timescale 1ns/1ps
`default_nettype none
module lbsd_lin_node (
    input wire logic clk,
    output logic rx
);
    initial rx = 1'b1;
    // ------------------------------------------------------------
    // line drive, always changed just after a clock edge
    // ------------------------------------------------------------
    task automatic hold(input logic lvl, input int cyc);
        @(posedge clk);
        rx <= lvl;
        repeat (cyc - 1) @(posedge clk);
    endtask
    // break then a one-bit delimiter
    task automatic send_break(input int bits, input int bitc);
        hold(1'b0, bits * bitc);
        hold(1'b1, bitc);
    endtask
    // start bit, data lsb first, stop bit
    task automatic send_byte(input logic [7:0] b, input int bitc);
        hold(1'b0, bitc);
        for (int i = 0; i < 8; i++) begin
            hold(b[i], bitc);
        end
        hold(1'b1, bitc);
    endtask
endmodule
`default_nettype wire

// ==== testbench/lbsd_top_test.sv ====
// Purpose: register and link level checks of the lin break/sync block
// Assumes: prescaler 0 gives one tick per clk
// Notes: the timeout run needs the full 16-bit counter, about 66k cycles
`timescale 1ns/1ps
`default_nettype none
module lbsd_top_test;
    localparam logic [7:0] CTRL = lbsd_pkg::LBSD_OFS_CTRL;
    localparam logic [7:0] STAT = lbsd_pkg::LBSD_OFS_IRQ_STATUS;
    localparam logic [7:0] MASK = lbsd_pkg::LBSD_OFS_IRQ_MASK;
    localparam logic [7:0] BAUD = lbsd_pkg::LBSD_OFS_BAUD;
    localparam logic [1:0] OK = lbsd_pkg::LBSD_RESP_OKAY;
    localparam logic [1:0] ERR = lbsd_pkg::LBSD_RESP_SLVERR;
    localparam int BIT = 24;
    logic clk = 1'b0;
    logic reset_n;
    logic ce;
    wire rx;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, baud_reload_load, irq;
    logic [1:0] bresp, rresp;
    logic [15:0] baud_reload;
    int n_errors = 0;
    int compares = 0;
    int n_loads = 0;
    int n;
    always #5 clk = ~clk;
    lbsd_top uut (
        .clk(clk), .reset_n(reset_n), .ce(ce), .rx_pin(rx),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .baud_reload(baud_reload),
        .baud_reload_load(baud_reload_load), .irq(irq)
    );
    lbsd_lin_node node (.clk(clk), .rx(rx));
    always @(posedge clk) begin
        if (baud_reload_load === 1'b1) n_loads <= n_loads + 1;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 50);
        bready <= 1'b0;
        if (bvalid !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        check({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int k;
        k = 0;
        @(posedge clk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 50);
        rready <= 1'b0;
        if (rvalid !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
    endtask
    // irq is combinational of registers: let the write land first
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        #1;
        check({31'h0, irq}, {31'h0, e});
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rd(CTRL, 32'h0, OK);
        rd(MASK, 32'h7, OK);
        rd(BAUD, {3'h0, lbsd_pkg::LBSD_IDLE, 24'h10}, OK);
        rd(8'h10, 32'h0, ERR);
        wr(8'h10, 32'hff, ERR);
        wr(CTRL, 32'h7, OK);
        rd(CTRL, 32'h7, OK);
        // byte-0 registers ignore a write without its strobe
        wstrb <= 4'h0;
        wr(CTRL, 32'h0, OK);
        rd(CTRL, 32'h7, OK);
        wstrb <= 4'hf;
        wr(BAUD, 32'h0002_0018, OK);
        rd(BAUD, {3'h0, lbsd_pkg::LBSD_IDLE, 8'h02, 16'h0018}, OK);
        wr(BAUD, 32'h0000_0010, OK);
        rd(BAUD, {3'h0, lbsd_pkg::LBSD_IDLE, 24'h10}, OK);
        chk_irq(1'b0);
        $display("test registers done");
        // sync word with no break ahead of it must be ignored
        wr(CTRL, 32'h8, OK);
        node.send_byte(8'h55, BIT);
        repeat (10) @(posedge clk);
        rd(CTRL, 32'h8, OK);
        check(n_loads, 0);
        $display("test no break done");
        wr(CTRL, 32'h0, OK);
        wr(CTRL, 32'h8, OK);
        node.send_break(14, BIT);
        node.send_byte(8'h55, BIT);
        repeat (10) @(posedge clk);
        check(n_loads, 1);
        check({16'h0, baud_reload}, BIT);
        rd(CTRL, 32'h58, OK);
        rd(STAT, 32'h5, OK);
        chk_irq(1'b0);
        wr(CTRL, 32'h59, OK);
        chk_irq(1'b1);
        wr(CTRL, 32'h4c, OK);
        rd(CTRL, 32'h4c, OK);
        chk_irq(1'b1);
        wr(CTRL, 32'h8, OK);
        chk_irq(1'b0);
        $display("test sync done");
        // start bit then silence: measurement runs out
        wr(CTRL, 32'h0, OK);
        wr(CTRL, 32'ha, OK);
        node.send_break(14, BIT);
        node.hold(1'b0, BIT);
        node.hold(1'b1, 1);
        n = 0;
        while (irq !== 1'b1 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        if (irq !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        check(n_loads, 1);
        check({16'h0, baud_reload}, BIT);
        rd(CTRL, 32'h6a, OK);
        wr(CTRL, 32'h68, OK);
        chk_irq(1'b0);
        wr(CTRL, 32'h6a, OK);
        chk_irq(1'b1);
        wr(MASK, 32'h5, OK);
        chk_irq(1'b0);
        wr(MASK, 32'h7, OK);
        wr(STAT, 32'h2, OK);
        rd(STAT, 32'h4, OK);
        chk_irq(1'b0);
        $display("test timeout done");
        end_of_test();
    end
endmodule
`default_nettype wire
